// [amss_pkg.sv]
// ************************************************************
// Shared constants for the asynchronous memory strobe sequencer.
// ************************************************************
package amss_pkg;

  // Interface geometry for the wide and the narrow instance.
  localparam int NUM_CE    = 4;
  localparam int CE_W      = 2;
  localparam int ADDR_W    = 20;
  localparam int WIDE_DW   = 64;
  localparam int NARROW_DW = 16;
  localparam int CNT_W     = 6;
  localparam int SETUP_W   = 4;
  localparam int STROBE_W  = 6;
  localparam int HOLD_W    = 3;
  localparam int REG_AW    = 8;

  // Register byte offsets on the AHB-Lite port.
  localparam logic [REG_AW-1:0] OFS_CECFG0 = 8'h00;
  localparam logic [REG_AW-1:0] OFS_CECFG1 = 8'h04;
  localparam logic [REG_AW-1:0] OFS_CECFG2 = 8'h08;
  localparam logic [REG_AW-1:0] OFS_CECFG3 = 8'h0C;
  localparam logic [REG_AW-1:0] OFS_ADDR   = 8'h10;
  localparam logic [REG_AW-1:0] OFS_WDLO   = 8'h14;
  localparam logic [REG_AW-1:0] OFS_WDHI   = 8'h18;
  localparam logic [REG_AW-1:0] OFS_CTRL   = 8'h1C;
  localparam logic [REG_AW-1:0] OFS_STAT   = 8'h20;
  localparam logic [REG_AW-1:0] OFS_RDLO   = 8'h24;
  localparam logic [REG_AW-1:0] OFS_RDHI   = 8'h28;

  // Field positions inside the per-space timing word.
  localparam int RS_LSB  = 0;
  localparam int RST_LSB = 4;
  localparam int RH_LSB  = 10;
  localparam int WS_LSB  = 16;
  localparam int WST_LSB = 20;
  localparam int WH_LSB  = 28;
  localparam logic [31:0] CFG_RESET = 32'h1021_0421;

  // Fields of the address, control and status registers.
  localparam int ADDR_LSB      = 0;
  localparam int CE_SEL_LSB    = 24;
  localparam int CTRL_WR_BIT   = 0;
  localparam int CTRL_BE_LSB   = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_EXT_BIT  = 1;

  // Phase selectors and counter landmarks.
  localparam logic [1:0]       PH_SETUP  = 2'h0;
  localparam logic [1:0]       PH_STROBE = 2'h1;
  localparam logic [1:0]       PH_HOLD   = 2'h2;
  localparam logic [CNT_W-1:0] CNT_ONE   = 6'h01;
  localparam logic [CNT_W-1:0] RDY_CHECK = 6'h02;
  localparam logic [1:0]       HTRANS_NONSEQ = 2'h2;

  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_SETUP  = 4'h2,
    ST_STROBE = 4'h4,
    ST_HOLD   = 4'h8
  } amss_state_t;

endpackage : amss_pkg

// [amss_ready_sync.sv]
`timescale 1ns/1ps
// ************************************************************
// Two-flop synchroniser for the memory ready input.
// ************************************************************
module amss_ready_sync (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic rdyAsync,
  output logic      rdySync
);
  import amss_pkg::*;

  logic stage1_r;
  logic stage2_r;
  logic stage1_nxt;
  logic stage2_nxt;

  // Next values: ready reads high while in reset so no stretch is seen.
  always_comb begin
    stage1_nxt = reset_n ? rdyAsync : 1'b1;
    stage2_nxt = reset_n ? stage1_r : 1'b1;
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    stage1_r <= stage1_nxt;
    stage2_r <= stage2_nxt;
  end

  assign rdySync = stage2_r;

  // ************************************************************
  // Checks.
  // ************************************************************
  property p_sync_delay;
    @(posedge clk) disable iff (!reset_n)
      $past(reset_n, 2) |-> rdySync == $past(rdyAsync, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("Ready synchroniser delay is not two cycles.");

endmodule : amss_ready_sync

// [amss_sequencer.sv]
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module amss_sequencer #(
  parameter int DATA_W = amss_pkg::WIDE_DW,
  parameter int BE_W   = DATA_W / 8
) (
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic                          hready,
  input  wire logic [31:0]                   hwdata,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic      [amss_pkg::NUM_CE-1:0]   chip_select_n,
  output logic      [BE_W-1:0]               byte_lane_enables_n,
  output logic      [amss_pkg::ADDR_W-1:0]   memory_address,
  output logic                               output_enable_n,
  output logic                               read_strobe_n,
  output logic                               write_strobe_n,
  output logic      [DATA_W-1:0]             memory_data_out,
  output logic                               memory_data_oe,
  input  wire logic [DATA_W-1:0]             memory_data_in,
  input  wire logic                          memory_ready_in
);
  import amss_pkg::*;

  // Phase length from a timing word; a zero field acts as one period.
  function automatic logic [CNT_W-1:0] phaseLen(input logic [31:0] cfg,
                                                input logic        wr,
                                                input logic [1:0]  ph);
    logic [CNT_W-1:0] v;
    v = '0;
    case (ph)
      PH_SETUP:  v = wr ? CNT_W'(cfg[WS_LSB +: SETUP_W]) : CNT_W'(cfg[RS_LSB +: SETUP_W]);
      PH_STROBE: v = wr ? cfg[WST_LSB +: STROBE_W] : cfg[RST_LSB +: STROBE_W];
      default:   v = wr ? CNT_W'(cfg[WH_LSB +: HOLD_W]) : CNT_W'(cfg[RH_LSB +: HOLD_W]);
    endcase
    if (v == '0) begin
      v = CNT_ONE;
    end
    return v;
  endfunction : phaseLen

  // ************************************************************
  // AHB-Lite register slave.
  // ************************************************************
  logic [31:0]       ceCfg_r [NUM_CE];
  logic [31:0]       ceCfg_nxt [NUM_CE];
  logic [31:0]       addrReg_r, addrReg_nxt;
  logic [31:0]       wdLo_r, wdLo_nxt;
  logic [31:0]       wdHi_r, wdHi_nxt;
  logic [31:0]       hrdata_r, hrdata_nxt;
  logic              dpWr_r, dpWr_nxt;
  logic [REG_AW-1:0] dpAddr_r, dpAddr_nxt;
  logic [63:0]       rdata_r, rdata_nxt;
  logic              extended_r, extended_nxt;
  amss_state_t       state_r, state_nxt;
  logic              startReq;
  logic              rdySync;
  logic              apValid;

  assign apValid   = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign startReq  = dpWr_r && (dpAddr_r == OFS_CTRL) && (state_r == ST_IDLE);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // Per-space timing words are plain storage, one per chip select.
  for (genvar g = 0; g < NUM_CE; g++) begin : g_cecfg
    always_comb begin
      ceCfg_nxt[g] = ceCfg_r[g];
      if (!reset_n) begin
        ceCfg_nxt[g] = CFG_RESET;
      end else if (dpWr_r && dpAddr_r == OFS_CECFG0 + REG_AW'(4 * g)) begin
        ceCfg_nxt[g] = hwdata;
      end
    end
    always_ff @(posedge clk) begin
      ceCfg_r[g] <= ceCfg_nxt[g];
    end
  end

  // Address phase capture, data phase writes and registered read data.
  always_comb begin
    dpWr_nxt    = apValid && hwrite;
    dpAddr_nxt  = haddr[REG_AW-1:0];
    addrReg_nxt = addrReg_r;
    wdLo_nxt    = wdLo_r;
    wdHi_nxt    = wdHi_r;
    hrdata_nxt  = hrdata_r;
    if (dpWr_r) begin
      case (dpAddr_r)
        OFS_ADDR: addrReg_nxt = hwdata;
        OFS_WDLO: wdLo_nxt    = hwdata;
        OFS_WDHI: wdHi_nxt    = hwdata;
        default:  addrReg_nxt = addrReg_r;
      endcase
    end
    if (apValid && !hwrite) begin
      case (haddr[REG_AW-1:0])
        OFS_CECFG0: hrdata_nxt = ceCfg_nxt[0];
        OFS_CECFG1: hrdata_nxt = ceCfg_nxt[1];
        OFS_CECFG2: hrdata_nxt = ceCfg_nxt[2];
        OFS_CECFG3: hrdata_nxt = ceCfg_nxt[3];
        OFS_ADDR:   hrdata_nxt = addrReg_nxt;
        OFS_WDLO:   hrdata_nxt = wdLo_nxt;
        OFS_WDHI:   hrdata_nxt = wdHi_nxt;
        OFS_STAT: begin
          hrdata_nxt = '0;
          hrdata_nxt[STAT_BUSY_BIT] = (state_nxt != ST_IDLE);
          hrdata_nxt[STAT_EXT_BIT]  = extended_nxt;
        end
        OFS_RDLO:   hrdata_nxt = rdata_nxt[31:0];
        OFS_RDHI:   hrdata_nxt = rdata_nxt[63:32];
        default:    hrdata_nxt = '0;
      endcase
    end
    if (!reset_n) begin
      dpWr_nxt    = 1'b0;
      dpAddr_nxt  = '0;
      addrReg_nxt = '0;
      wdLo_nxt    = '0;
      wdHi_nxt    = '0;
      hrdata_nxt  = '0;
    end
  end

  // Bus-side registers.
  always_ff @(posedge clk) begin
    dpWr_r    <= dpWr_nxt;
    dpAddr_r  <= dpAddr_nxt;
    addrReg_r <= addrReg_nxt;
    wdLo_r    <= wdLo_nxt;
    wdHi_r    <= wdHi_nxt;
    hrdata_r  <= hrdata_nxt;
  end

  // ************************************************************
  // Ready synchroniser and access sequencer.
  // ************************************************************
  amss_ready_sync u_rdy (
    .clk      (clk),
    .reset_n  (reset_n),
    .rdyAsync (memory_ready_in),
    .rdySync  (rdySync)
  );

  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic [31:0]       actCfg_r, actCfg_nxt;
  logic              isWr_r, isWr_nxt;
  logic              waitSeen_r, waitSeen_nxt;
  logic [CE_W-1:0]   ceSel;
  logic [31:0]       newCfg;
  logic              selActive;
  logic [NUM_CE-1:0] cs_r, cs_nxt;
  logic [BE_W-1:0]   be_r, be_nxt, beHeld_r, beHeld_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  logic              oe_r, oe_nxt, re_r, re_nxt, we_r, we_nxt, doe_r, doe_nxt;

  assign ceSel  = addrReg_r[CE_SEL_LSB +: CE_W];
  assign newCfg = ceCfg_r[ceSel];

  // Phase sequencing; every count below is in whole clock periods.
  always_comb begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    actCfg_nxt   = actCfg_r;
    isWr_nxt     = isWr_r;
    waitSeen_nxt = waitSeen_r;
    extended_nxt = extended_r;
    rdata_nxt    = rdata_r;
    addr_nxt     = addr_r;
    dout_nxt     = dout_r;
    beHeld_nxt   = beHeld_r;
    case (state_r)
      ST_IDLE: if (startReq) begin
        state_nxt    = ST_SETUP;
        actCfg_nxt   = newCfg;
        isWr_nxt     = hwdata[CTRL_WR_BIT];
        cnt_nxt      = phaseLen(newCfg, hwdata[CTRL_WR_BIT], PH_SETUP);
        waitSeen_nxt = 1'b0;
        addr_nxt     = addrReg_r[ADDR_LSB +: ADDR_W];
        dout_nxt     = DATA_W'({wdHi_r, wdLo_r});
        beHeld_nxt   = hwdata[CTRL_BE_LSB +: BE_W];
      end
      ST_SETUP: if (cnt_r == CNT_ONE) begin
        state_nxt = ST_STROBE;
        cnt_nxt   = phaseLen(actCfg_r, isWr_r, PH_STROBE);
      end else begin
        cnt_nxt = cnt_r - CNT_ONE;
      end
      ST_STROBE: if (cnt_r == RDY_CHECK && !rdySync) begin
        waitSeen_nxt = 1'b1;
      end else if (cnt_r == CNT_ONE) begin
        state_nxt    = ST_HOLD;
        cnt_nxt      = phaseLen(actCfg_r, isWr_r, PH_HOLD);
        extended_nxt = waitSeen_r;
        if (!isWr_r) begin
          rdata_nxt = '0;
          rdata_nxt[DATA_W-1:0] = memory_data_in;
        end
      end else begin
        cnt_nxt = cnt_r - CNT_ONE;
      end
      ST_HOLD: if (cnt_r == CNT_ONE) begin
        state_nxt = ST_IDLE;
      end else begin
        cnt_nxt = cnt_r - CNT_ONE;
      end
      default: state_nxt = ST_IDLE;
    endcase
    // Pin values registered so they move together at one clock edge.
    selActive = (state_nxt != ST_IDLE);
    cs_nxt    = '1;
    if (selActive) begin
      cs_nxt[ceSelHeld(actCfg_nxt)] = 1'b0;
    end
    be_nxt  = selActive ? ~beHeld_nxt : '1;
    oe_nxt  = !(selActive && !isWr_nxt);
    re_nxt  = !(state_nxt == ST_STROBE && !isWr_nxt);
    we_nxt  = !(state_nxt == ST_STROBE && isWr_nxt);
    doe_nxt = selActive && isWr_nxt;
    if (!reset_n) begin
      state_nxt    = ST_IDLE;
      cnt_nxt      = '0;
      actCfg_nxt   = '0;
      isWr_nxt     = 1'b0;
      waitSeen_nxt = 1'b0;
      extended_nxt = 1'b0;
      rdata_nxt    = '0;
      addr_nxt     = '0;
      dout_nxt     = '0;
      beHeld_nxt   = '0;
      cs_nxt       = '1;
      be_nxt       = '1;
      oe_nxt       = 1'b1;
      re_nxt       = 1'b1;
      we_nxt       = 1'b1;
      doe_nxt      = 1'b0;
    end
  end

  // Chip select of the running access, held beside its timing word.
  logic [CE_W-1:0] ceHeld_r, ceHeld_nxt;
  function automatic logic [CE_W-1:0] ceSelHeld(input logic [31:0] unused);
    return ceHeld_nxt;
  endfunction : ceSelHeld

  always_comb begin
    ceHeld_nxt = ceHeld_r;
    if (!reset_n) begin
      ceHeld_nxt = '0;
    end else if (startReq) begin
      ceHeld_nxt = ceSel;
    end
  end

  // Sequencer and pin registers.
  always_ff @(posedge clk) begin
    state_r    <= state_nxt;
    cnt_r      <= cnt_nxt;
    actCfg_r   <= actCfg_nxt;
    isWr_r     <= isWr_nxt;
    waitSeen_r <= waitSeen_nxt;
    extended_r <= extended_nxt;
    rdata_r    <= rdata_nxt;
    addr_r     <= addr_nxt;
    dout_r     <= dout_nxt;
    beHeld_r   <= beHeld_nxt;
    ceHeld_r   <= ceHeld_nxt;
    cs_r       <= cs_nxt;
    be_r       <= be_nxt;
    oe_r       <= oe_nxt;
    re_r       <= re_nxt;
    we_r       <= we_nxt;
    doe_r      <= doe_nxt;
  end

  assign chip_select_n       = cs_r;
  assign byte_lane_enables_n = be_r;
  assign memory_address      = addr_r;
  assign output_enable_n     = oe_r;
  assign read_strobe_n       = re_r;
  assign write_strobe_n      = we_r;
  assign memory_data_out     = dout_r;
  assign memory_data_oe      = doe_r;

  // ************************************************************
  // Checks.
  // ************************************************************
  logic [7:0] phaseCnt_r;
  always_ff @(posedge clk) begin
    phaseCnt_r <= (!reset_n || state_nxt != state_r) ? 8'h00 : phaseCnt_r + 8'h01;
  end

  property p_rd_setup;
    @(posedge clk) disable iff (!reset_n)
      (state_r == ST_SETUP && state_nxt == ST_STROBE && !isWr_r)
        |-> CNT_W'(phaseCnt_r + 8'h01) == phaseLen(actCfg_r, 1'b0, PH_SETUP);
  endproperty
  a_rd_setup: assert property (p_rd_setup)
    else $error("Read setup length differs from programmed count.");

  property p_rd_hold;
    @(posedge clk) disable iff (!reset_n)
      (state_r == ST_HOLD && state_nxt == ST_IDLE && !isWr_r)
        |-> CNT_W'(phaseCnt_r + 8'h01) == phaseLen(actCfg_r, 1'b0, PH_HOLD);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("Read hold length differs from programmed count.");

  property p_wr_setup;
    @(posedge clk) disable iff (!reset_n)
      $fell(write_strobe_n) |-> memory_data_oe && $past(memory_data_oe) &&
        $past(cs_r) == cs_r &&
        $past(memory_data_out) == memory_data_out;
  endproperty
  a_wr_setup: assert property (p_wr_setup)
    else $error("Write data not held across the write strobe fall.");

  property p_wr_hold;
    @(posedge clk) disable iff (!reset_n)
      (state_r == ST_HOLD && isWr_r) |-> memory_data_oe && !(&chip_select_n);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("Write selects dropped during hold.");

  property p_strobe_edge;
    @(posedge clk) disable iff (!reset_n)
      $changed(read_strobe_n) |-> state_r != $past(state_r);
  endproperty
  a_strobe_edge: assert property (p_strobe_edge)
    else $error("Read strobe moved without a phase change.");

  property p_capture;
    @(posedge clk) disable iff (!reset_n)
      $rose(read_strobe_n) |-> rdata_r[DATA_W-1:0] == $past(memory_data_in);
  endproperty
  a_capture: assert property (p_capture)
    else $error("Read data not captured at strobe rise.");

  property p_ignore_early;
    @(posedge clk) disable iff (!reset_n)
      (state_r == ST_STROBE && cnt_r > RDY_CHECK) |=> cnt_r == $past(cnt_r) - CNT_ONE;
  endproperty
  a_ignore_early: assert property (p_ignore_early)
    else $error("Strobe count stalled before the ready check point.");

  property p_stretch;
    @(posedge clk) disable iff (!reset_n)
      (state_r == ST_STROBE && cnt_r == RDY_CHECK && !rdySync)
        |=> state_r == ST_STROBE && cnt_r == RDY_CHECK && (!read_strobe_n || !write_strobe_n);
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("Strobe not extended while ready low.");

  property p_release;
    @(posedge clk) disable iff (!reset_n)
      (state_r == ST_STROBE && cnt_r == RDY_CHECK && rdySync && waitSeen_r)
        |-> ##1 state_r == ST_STROBE ##1 state_r == ST_HOLD;
  endproperty
  a_release: assert property (p_release)
    else $error("Strobe did not end two cycles after ready high.");

  property p_strobe_len;
    @(posedge clk) disable iff (!reset_n)
      (state_r == ST_STROBE && state_nxt == ST_HOLD && !waitSeen_r)
        |-> CNT_W'(phaseCnt_r + 8'h01) == phaseLen(actCfg_r, isWr_r, PH_STROBE);
  endproperty
  a_strobe_len: assert property (p_strobe_len)
    else $error("Strobe length differs from programmed count.");

  property p_order;
    @(posedge clk) disable iff (!reset_n)
      $rose(state_r == ST_STROBE) |-> $past(state_r) == ST_SETUP;
  endproperty
  a_order: assert property (p_order)
    else $error("Strobe entered without a setup phase.");

  c_read:    cover property (@(posedge clk) disable iff (!reset_n)
                             $rose(read_strobe_n) && !isWr_r);
  c_write:   cover property (@(posedge clk) disable iff (!reset_n)
                             $rose(write_strobe_n));
  c_stretch: cover property (@(posedge clk) disable iff (!reset_n)
                             state_r == ST_STROBE && waitSeen_r ##1 state_r == ST_HOLD);

endmodule : amss_sequencer

// [amss_mem_model.sv]
`timescale 1ns/1ps
// ************************************************************
// Asynchronous memory with a ready output.
// ************************************************************
module amss_mem_model #(
  parameter int DW = 64
) (
  input  wire logic          clk,
  input  wire logic [3:0]    csN,
  input  wire logic          oeN,
  input  wire logic          weN,
  input  wire logic [19:0]   addr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [7:0]    stallLen,
  output logic      [DW-1:0] rdata,
  output logic               ready
);
  logic [DW-1:0] mem [16];
  logic [DW-1:0] lastVal = '0;
  logic [7:0]    cnt = 8'h00;
  logic          selD = 1'b0;
  wire           sel = (csN != 4'hF);
  // Stores the write data as the write strobe rises.
  always @(posedge weN) begin
    if (sel) mem[addr[3:0]] <= wdata;
  end
  // Unselected, the data lines show the inverse of the last value read.
  assign rdata = (sel && !oeN) ? mem[addr[3:0]] : ~lastVal;
  // Holds ready low for stallLen whole periods from the start of an access.
  always @(posedge clk) begin
    selD <= sel;
    if (sel && !selD) cnt <= stallLen;
    else if (cnt != 8'h00) cnt <= cnt - 8'h01;
    if (sel && !oeN) lastVal <= mem[addr[3:0]];
  end
  assign ready = (cnt == 8'h00);
endmodule : amss_mem_model

// [amss_sequencer_tb_top.sv]
`timescale 1ns/1ps
// ************************************************************
// Self-checking bench for the wide sequencer.
// ************************************************************
module amss_sequencer_tb_top;
  import amss_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [3:0]  csN;
  logic [7:0]  beN;
  logic [19:0] addr;
  logic        oeN;
  logic        reN;
  logic        weN;
  logic [63:0] dOut;
  logic        dOe;
  logic [63:0] dIn;
  logic        rdy;
  logic [7:0]  stallLen = 8'h00;
  logic [31:0] r;
  logic [31:0] cfg;
  int          n_fail = 0;
  int          comparisons = 0;
  int          ns;
  int          nt;
  int          nh;

  amss_sequencer #(.DATA_W(WIDE_DW)) dut_u (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .chip_select_n(csN), .byte_lane_enables_n(beN),
    .memory_address(addr), .output_enable_n(oeN), .read_strobe_n(reN),
    .write_strobe_n(weN), .memory_data_out(dOut), .memory_data_oe(dOe),
    .memory_data_in(dIn), .memory_ready_in(rdy));

  amss_mem_model #(.DW(WIDE_DW)) mem_u (
    .clk(clk), .csN(csN), .oeN(oeN), .weN(weN), .addr(addr), .wdata(dOut),
    .stallLen(stallLen), .rdata(dIn), .ready(rdy));

  // Free-running 10 MHz clock.
  initial begin
    forever #50 clk = ~clk;
  end

  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // Waits for hready high at a rising edge, within a bound.
  task automatic waitRdy();
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      if (hreadyout === 1'b1) return;
    end
    n_fail++;
    tally_and_finish();
  endtask : waitRdy

  // One single-word bus transfer: address phase, then data phase.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    waitRdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitRdy();
    rd = hrdata;
  endtask : bus

  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wrReg

  task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0, d);
  endtask : rdReg

  function automatic int one(input int v);
    return (v == 0) ? 1 : v;
  endfunction : one

  // Runs one access and measures its phases and its select group.
  task automatic access(input logic wr, input logic [1:0] ce, input logic [19:0] a,
                        input logic [7:0] be, input logic [63:0] d,
                        input int es, input int et, input int eh);
    int          err;
    logic [97:0] snap;
    logic [31:0] lo;
    err = 0;
    ns = 0;
    nt = 0;
    nh = 0;
    wrReg(OFS_ADDR, {6'h0, ce, 4'h0, a});
    wrReg(OFS_WDLO, d[31:0]);
    wrReg(OFS_WDHI, d[63:32]);
    wrReg(OFS_CTRL, {16'h0, be, 7'h0, wr});
    for (int i = 0; i < 200; i++) begin
      #1;
      if (i == 0) snap = {csN, beN, oeN, dOe, addr, dOut};
      if (csN === 4'hF) break;
      if ({csN, beN, oeN, dOe, addr, dOut} !== snap) err++;
      if ((wr ? reN : weN) !== 1'b1) err++;
      if ((wr ? weN : reN) === 1'b0) nt++;
      else if (nt == 0) ns++;
      else nh++;
      @(posedge clk);
    end
    chk(err, 0);
    chk(csN, 4'hF);
    chk(snap[97:64], {~(4'h1 << ce), ~be, wr, wr, a});
    chk(ns, es);
    chk(nt, et);
    chk(nh, eh);
    if (wr) chk(snap[63:0], d);
    else begin
      rdReg(OFS_RDLO, lo);
      rdReg(OFS_RDHI, r);
      chk({r, lo}, d);
    end
  endtask : access

  // Main sequence: reset, timing per space, then ready stretching.
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    chk({csN, beN, oeN, reN, weN, dOe, hrdata}, {4'hF, 8'hFF, 3'h7, 1'b0, 32'h0});
    for (int k = 0; k < 4; k++) begin
      rdReg(8'(4 * k), r);
      chk(r, CFG_RESET);
    end
    rdReg(8'h2C, r);
    chk(r, 32'h0);
    for (int k = 0; k < 4; k++) begin
      cfg = (k << RS_LSB) | ((k + 2) << RST_LSB) | (k << RH_LSB) | ((3 - k) << WS_LSB)
          | ((k + 1) << WST_LSB) | ((3 - k) << WH_LSB);
      wrReg(8'(4 * k), cfg);
      rdReg(8'(4 * k), r);
      chk(r, cfg);
      access(1'b1, 2'(k), 20'hABC30 + 20'(k), 8'h3C + 8'(k), 64'h0123_4567_89AB_CDEF + 64'(k),
             one(3 - k), k + 1, one(3 - k));
      access(1'b0, 2'(k), 20'hABC30 + 20'(k), 8'h3C + 8'(k), 64'h0123_4567_89AB_CDEF + 64'(k),
             one(k), k + 2, one(k));
    end
    wrReg(OFS_CECFG0, (1 << RS_LSB) | (4 << RST_LSB) | (1 << RH_LSB));
    stallLen <= 8'h06;
    access(1'b0, 2'h0, 20'hABC30, 8'hFF, 64'h0123_4567_89AB_CDEF, 1, 10, 1);
    rdReg(OFS_STAT, r);
    chk(r[1:0], 2'h2);
    wrReg(OFS_CECFG0, (1 << RS_LSB) | (6 << RST_LSB) | (1 << RH_LSB));
    stallLen <= 8'h02;
    access(1'b0, 2'h0, 20'hABC30, 8'hFF, 64'h0123_4567_89AB_CDEF, 1, 6, 1);
    rdReg(OFS_STAT, r);
    chk(r[1:0], 2'h0);
    tally_and_finish();
  end
endmodule : amss_sequencer_tb_top
